// [verilog/pscr_cfg.svh]
// offsets, field positions, reset values and timing counts of the synthesizer config bank
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH

`define PSCR_WORD_W        32
`define PSCR_ADDR_W        4
`define PSCR_ADDR_INT      4'h0
`define PSCR_ADDR_COARSE   4'h1
`define PSCR_ADDR_PHASE    4'h2
`define PSCR_ADDR_FNUM     4'h3
`define PSCR_ADDR_FDEN     4'h4
`define PSCR_ADDR_REFPUMP  4'h5
`define PSCR_ADDR_LOOP     4'h6
`define PSCR_ADDR_LAST     4'hD

`define PSCR_R0_VARMOD     28
`define PSCR_R1_DITHER     31
`define PSCR_R2_PHASE_EN   31
`define PSCR_R5_XMOD_OFF   24
`define PSCR_R5_PRESC      23
`define PSCR_R5_HALF       22
`define PSCR_R5_DBL        21
`define PSCR_R6_BLEED_POL  23
`define PSCR_R6_BLEED_EN   22
`define PSCR_R6_INT_MODE   20
`define PSCR_R6_ABP        19
`define PSCR_R6_LOL        18
`define PSCR_R6_SD_SKIP    17
`define PSCR_R6_CP_TRI_PD  16
`define PSCR_R6_PWR_DOWN   6
`define PSCR_R6_CP_TRI     5
`define PSCR_R6_CNT_RST    4

`define PSCR_LD_NORMAL     2'h1
`define PSCR_LD_TRISTATE   2'h0
`define PSCR_LD_HIGH       2'h2
`define PSCR_LD_LOW        2'h3
`define PSCR_RESET_WORD    32'h00000000

// modulator held at zero fraction this long after a commit
`define PSCR_SD_RST_NS     100
`define PSCR_CLK_MHZ       40
`define PSCR_SD_RST_CYC    ((`PSCR_SD_RST_NS * `PSCR_CLK_MHZ + 999) / 1000)

`endif

// [verilog/pscr_pkg.sv]
// types shared by the synthesizer config bank
package pscr_pkg;
   typedef logic [31:0] pscr_word_t;
   typedef logic [3:0]  pscr_addr_t;
   typedef enum logic [1:0] {
      PSCR_IDLE  = 2'b00,
      PSCR_SHIFT = 2'b01,
      PSCR_WAIT  = 2'b10
   } pscr_rx_e;
endpackage : pscr_pkg

// [verilog/pscr_pin_sync.sv]
// three-stage pin synchroniser; change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pscr_pin_sync
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      rise,
   output logic      fall
);
   logic [2:0] st_q;
   logic [2:0] st_d;
   logic       lvl_q;
   logic       lvl_d;

   always_comb
   begin
      st_d  = {st_q[1:0], pin_in};
      lvl_d = lvl_q;
      if (st_q[1] == st_q[2])
      begin
         lvl_d = st_q[2];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_q  <= 3'h0;
         lvl_q <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         lvl_q <= lvl_d;
      end
   end

   assign pin_out = lvl_q;
   assign rise    = lvl_d & ~lvl_q;
   assign fall    = ~lvl_d & lvl_q;
endmodule : pscr_pin_sync
`default_nettype wire

// [verilog/pscr_serial_rx.sv]
// three-wire serial receiver: shifts 32 bits msb first, word taken on load strobe rise, or on the next reference fall when align_en is set
`timescale 1ns/100ps
`default_nettype none
`include "pscr_cfg.svh"
module pscr_serial_rx
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              sclk_rise,
   input  wire logic              sdata,
   input  wire logic              strobe_rise,
   input  wire logic              align_en,
   input  wire logic              ref_fall,
   output pscr_pkg::pscr_word_t   word,
   output logic                   word_vld
);
   import pscr_pkg::*;

   pscr_word_t sh_q;
   pscr_word_t sh_d;
   pscr_word_t word_q;
   pscr_word_t word_d;
   logic       vld_q;
   logic       vld_d;
   pscr_rx_e   st_q;
   pscr_rx_e   st_d;

   always_comb
   begin
      sh_d   = sh_q;
      word_d = word_q;
      vld_d  = 1'b0;
      st_d   = st_q;
      if (sclk_rise)
      begin
         sh_d = {sh_q[30:0], sdata};
      end
      case (st_q)
         PSCR_IDLE, PSCR_SHIFT:
         begin
            if (strobe_rise)
            begin
               // without a reference the host must clear alignment, else no load
               if (align_en && !ref_fall)
               begin
                  st_d = PSCR_WAIT;
               end
               else
               begin
                  word_d = sh_q;
                  vld_d  = 1'b1;
                  st_d   = PSCR_IDLE;
               end
            end
         end
         PSCR_WAIT:
         begin
            if (ref_fall)
            begin
               word_d = sh_q;
               vld_d  = 1'b1;
               st_d   = PSCR_IDLE;
            end
         end
         default:
         begin
            st_d = PSCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sh_q   <= `PSCR_RESET_WORD;
         word_q <= `PSCR_RESET_WORD;
         vld_q  <= 1'b0;
         st_q   <= PSCR_IDLE;
      end
      else
      begin
         sh_q   <= sh_d;
         word_q <= word_d;
         vld_q  <= vld_d;
         st_q   <= st_d;
      end
   end

   assign word     = word_q;
   assign word_vld = vld_q;
endmodule : pscr_serial_rx
`default_nettype wire

// [verilog/pscr_config_regs.sv]
// write-only configuration bank of the synthesizer, registers zero to six
// Function
// - new frequency applies only when register zero is written
// - register zero bit 28 picks fixed 25-bit or variable modulus
// - register zero bits 19:4 hold the 16-bit integer divide value
// - register one bit 31 turns modulator dither on
// - register one bits 28:4 hold the 25-bit coarse numerator
// - phase advance by 12-bit value, applied on next register zero write
// - register three bits 27:4 fine numerator, ignored in fixed modulus
// - register four bits 27:4 fine denominator, ignored in fixed modulus
// - register five bits 31:30 set lock detect pin mode, 01 normal
// - register five bits 28:25 charge pump current code
// - register five bit 24 zero adds a 26th modulus bit
// - reference halver, doubler, 5-bit counter, 12-bit resync divider
// - register six bleed value, polarity and enable
// - register six bit 20 disables the modulator, pure integer mode
// - bit 19 antibacklash width; bit 18 drops lock on lost reference
// - bit 17 zero forces zero fraction briefly on register zero write
// - bit 16 or bit 5 three-states the charge pump
// - lock window set by precision bits 9:8 with external bias
// - bit 6 powers down all blocks, keeping register contents
// - bit 4 holds feedback divider and reference counter in reset
// - each serial access carries a 32-bit word
// - strobe rise aligned to reference falling edge when enabled
`timescale 1ns/100ps
`default_nettype none
`include "pscr_cfg.svh"
module pscr_config_regs
(
   input  wire logic  sys_clk,
   input  wire logic  rst_n,
   input  wire logic  ser_clk,
   input  wire logic  ser_data,
   input  wire logic  load_strobe,
   input  wire logic  ref_in,
   input  wire logic  ref_present,
   input  wire logic  lock_raw,
   input  wire logic  strobe_align_en,
   output logic       var_modulus,
   output logic [15:0] int_value,
   output logic       modulator_dither_en,
   output logic [24:0] coarse_numerator,
   output logic [23:0] fine_numerator,
   output logic [23:0] fine_denominator,
   output logic       phase_adjust_en,
   output logic [11:0] phase_value,
   output logic       phase_step,
   output logic [3:0] charge_pump_code,
   output logic       extra_modulus_bit_off,
   output logic       prescaler_sel,
   output logic       ref_half_divider_en,
   output logic       ref_doubler_en,
   output logic [4:0] ref_count,
   output logic [11:0] resync_divider_one,
   output logic [7:0] bleed_value,
   output logic       bleed_negative,
   output logic       bleed_en,
   output logic       sigma_delta_modulator_en,
   output logic       antibacklash_width,
   output logic [1:0] lock_window_precision,
   output logic       charge_pump_tristate,
   output logic       power_down,
   output logic       counters_reset,
   output logic       lock_detect_out,
   output logic       lock_detect_oe
);
   import pscr_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers and receiver
   // ------------------------------------------------------------
   logic       sclk_rise;
   logic       strobe_rise;
   logic       ref_fall;
   logic       ref_ok;
   pscr_word_t rx_word;
   logic       rx_vld;

   pscr_pin_sync u_sclk
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (ser_clk),
      .pin_out (),
      .rise    (sclk_rise),
      .fall    ()
   );

   logic sdata_s;

   pscr_pin_sync u_sdata
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (ser_data),
      .pin_out (sdata_s),
      .rise    (),
      .fall    ()
   );

   pscr_pin_sync u_strobe
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (load_strobe),
      .pin_out (),
      .rise    (strobe_rise),
      .fall    ()
   );

   pscr_pin_sync u_ref
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (ref_in),
      .pin_out (),
      .rise    (),
      .fall    (ref_fall)
   );

   pscr_pin_sync u_refok
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (ref_present),
      .pin_out (ref_ok),
      .rise    (),
      .fall    ()
   );

   logic lock_s;

   pscr_pin_sync u_lock
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (lock_raw),
      .pin_out (lock_s),
      .rise    (),
      .fall    ()
   );

   // data sampled at sys_clk edge after sclk rise; the rise strobe comes one cycle ahead of the synced data level
   pscr_serial_rx u_rx
   (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .sclk_rise   (sclk_rise),
      .sdata       (sdata_s),
      .strobe_rise (strobe_rise),
      .align_en    (strobe_align_en),
      .ref_fall    (ref_fall),
      .word        (rx_word),
      .word_vld    (rx_vld)
   );

   // ------------------------------------------------------------
   // register bank, with double buffers committed by register zero
   // ------------------------------------------------------------
   pscr_word_t r0_q, r0_d;
   pscr_word_t r1_q, r1_d;
   pscr_word_t r2_q, r2_d;
   pscr_word_t r3_q, r3_d;
   pscr_word_t r4_q, r4_d;
   pscr_word_t r5_q, r5_d;
   pscr_word_t r6_q, r6_d;
   pscr_word_t a1_q, a1_d;
   pscr_word_t a2_q, a2_d;
   pscr_word_t a3_q, a3_d;
   pscr_word_t a4_q, a4_d;
   logic       step_q, step_d;
   logic [7:0] sdr_q, sdr_d;
   logic       commit;

   function automatic logic addr_hit(input pscr_word_t w, input pscr_addr_t a);
      addr_hit = (w[3:0] == a);
   endfunction : addr_hit

   assign commit = rx_vld && addr_hit(rx_word, `PSCR_ADDR_INT);

   always_comb
   begin
      r0_d   = r0_q;
      r1_d   = r1_q;
      r2_d   = r2_q;
      r3_d   = r3_q;
      r4_d   = r4_q;
      r5_d   = r5_q;
      r6_d   = r6_q;
      a1_d   = a1_q;
      a2_d   = a2_q;
      a3_d   = a3_q;
      a4_d   = a4_q;
      step_d = 1'b0;
      sdr_d  = (sdr_q != 8'h00) ? sdr_q - 8'h01 : 8'h00;
      if (rx_vld)
      begin
         // addresses seven to thirteen belong to other blocks and are dropped here
         case (rx_word[3:0])
            `PSCR_ADDR_COARSE:  r1_d = rx_word;
            `PSCR_ADDR_PHASE:   r2_d = rx_word;
            `PSCR_ADDR_FNUM:    r3_d = rx_word;
            `PSCR_ADDR_FDEN:    r4_d = rx_word;
            `PSCR_ADDR_REFPUMP: r5_d = rx_word;
            `PSCR_ADDR_LOOP:    r6_d = rx_word;
            default:            r0_d = r0_q;
         endcase
      end
      if (commit)
      begin
         r0_d   = rx_word;
         a1_d   = r1_q;
         a2_d   = r2_q;
         a3_d   = r3_q;
         a4_d   = r4_q;
         step_d = r2_q[`PSCR_R2_PHASE_EN];
         if (!r6_q[`PSCR_R6_SD_SKIP])
         begin
            sdr_d = 8'(`PSCR_SD_RST_CYC);
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         r0_q   <= `PSCR_RESET_WORD;
         r1_q   <= `PSCR_RESET_WORD;
         r2_q   <= `PSCR_RESET_WORD;
         r3_q   <= `PSCR_RESET_WORD;
         r4_q   <= `PSCR_RESET_WORD;
         r5_q   <= `PSCR_RESET_WORD;
         r6_q   <= `PSCR_RESET_WORD;
         a1_q   <= `PSCR_RESET_WORD;
         a2_q   <= `PSCR_RESET_WORD;
         a3_q   <= `PSCR_RESET_WORD;
         a4_q   <= `PSCR_RESET_WORD;
         step_q <= 1'b0;
         sdr_q  <= 8'h00;
      end
      else
      begin
         r0_q   <= r0_d;
         r1_q   <= r1_d;
         r2_q   <= r2_d;
         r3_q   <= r3_d;
         r4_q   <= r4_d;
         r5_q   <= r5_d;
         r6_q   <= r6_d;
         a1_q   <= a1_d;
         a2_q   <= a2_d;
         a3_q   <= a3_d;
         a4_q   <= a4_d;
         step_q <= step_d;
         sdr_q  <= sdr_d;
      end
   end

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   logic sd_zero;

   assign sd_zero             = (sdr_q != 8'h00);
   assign var_modulus         = r0_q[`PSCR_R0_VARMOD];
   assign int_value           = r0_q[19:4];
   assign modulator_dither_en = a1_q[`PSCR_R1_DITHER];
   assign coarse_numerator    = sd_zero ? 25'h0 : a1_q[28:4];
   // fixed modulus: fine terms forced to zero so the divider ignores them
   assign fine_numerator      = (var_modulus && !sd_zero) ? a3_q[27:4] : 24'h0;
   assign fine_denominator    = var_modulus ? a4_q[27:4] : 24'h0;
   assign phase_adjust_en     = a2_q[`PSCR_R2_PHASE_EN];
   assign phase_value         = a2_q[15:4];
   assign phase_step          = step_q;
   assign charge_pump_code    = r5_q[28:25];
   assign extra_modulus_bit_off = r5_q[`PSCR_R5_XMOD_OFF];
   assign prescaler_sel       = r5_q[`PSCR_R5_PRESC];
   assign ref_half_divider_en = r5_q[`PSCR_R5_HALF];
   assign ref_doubler_en      = r5_q[`PSCR_R5_DBL];
   assign ref_count           = r5_q[20:16];
   assign resync_divider_one  = r5_q[15:4];
   assign bleed_value         = r6_q[31:24];
   assign bleed_negative      = r6_q[`PSCR_R6_BLEED_POL];
   assign bleed_en            = r6_q[`PSCR_R6_BLEED_EN];
   assign sigma_delta_modulator_en = ~r6_q[`PSCR_R6_INT_MODE];
   assign antibacklash_width  = r6_q[`PSCR_R6_ABP];
   assign lock_window_precision = r6_q[9:8];
   assign charge_pump_tristate = r6_q[`PSCR_R6_CP_TRI_PD] | r6_q[`PSCR_R6_CP_TRI];
   assign power_down          = r6_q[`PSCR_R6_PWR_DOWN];
   assign counters_reset      = r6_q[`PSCR_R6_CNT_RST];

   // ------------------------------------------------------------
   // lock detect pin
   // ------------------------------------------------------------
   logic ld_q, ld_d;
   logic ld_oe_q, ld_oe_d;

   always_comb
   begin
      ld_d    = 1'b0;
      ld_oe_d = 1'b1;
      case (r5_q[31:30])
         `PSCR_LD_NORMAL:
         begin
            // lost reference drops lock when enabled
            ld_d = lock_s && !(r6_q[`PSCR_R6_LOL] && !ref_ok) && !power_down;
         end
         `PSCR_LD_HIGH:     ld_d = 1'b1;
         `PSCR_LD_LOW:      ld_d = 1'b0;
         default:           ld_oe_d = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ld_q    <= 1'b0;
         ld_oe_q <= 1'b0;
      end
      else
      begin
         ld_q    <= ld_d;
         ld_oe_q <= ld_oe_d;
      end
   end

   assign lock_detect_out = ld_q;
   assign lock_detect_oe  = ld_oe_q;
endmodule : pscr_config_regs
`default_nettype wire

// [dv/pscr_config_regs_asserts.sv]
// assertion checker for the synthesizer config bank
`timescale 1ns/100ps
`default_nettype none
module pscr_config_regs_asserts
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        load_strobe,
   input  wire logic        var_modulus,
   input  wire logic [15:0] int_value,
   input  wire logic        modulator_dither_en,
   input  wire logic [24:0] coarse_numerator,
   input  wire logic [23:0] fine_numerator,
   input  wire logic [23:0] fine_denominator,
   input  wire logic        phase_adjust_en,
   input  wire logic        phase_step,
   input  wire logic [3:0]  charge_pump_code,
   input  wire logic [7:0]  bleed_value
);
   // ----------------------------------------
   // cycles since last strobe rise
   // ----------------------------------------
   logic       ls_q, ls_d;
   logic [7:0] age_q, age_d;
   // saturates so an old strobe never looks fresh again
   always_comb
   begin
      ls_d  = load_strobe;
      age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
      if (load_strobe && !ls_q)
      begin
         age_d = 8'h00;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      ls_q  <= rst_n ? ls_d : 1'b0;
      age_q <= rst_n ? age_d : 8'hFF;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_step_one; phase_step |=> !phase_step [*3]; endproperty
   a_step_one: assert property (p_step_one) else $error("phase step too long");
   property p_step_en; phase_step |-> phase_adjust_en && age_q <= 8'd40; endproperty
   a_step_en: assert property (p_step_en) else $error("stray phase step");
   property p_fixed_fine; !var_modulus |-> fine_numerator == 24'h0 && fine_denominator == 24'h0;
   endproperty
   a_fixed_fine: assert property (p_fixed_fine) else $error("fine used in fixed");
   property p_int; $changed(int_value) |-> age_q <= 8'd40; endproperty
   a_int: assert property (p_int) else $error("int moved unwritten");
   property p_coarse; $changed(coarse_numerator) |-> age_q <= 8'd40; endproperty
   a_coarse: assert property (p_coarse) else $error("coarse moved uncommitted");
   property p_dither; $changed(modulator_dither_en) |-> age_q <= 8'd40; endproperty
   a_dither: assert property (p_dither) else $error("dither moved unwritten");
   property p_pump; $changed(charge_pump_code) |-> age_q <= 8'd40; endproperty
   a_pump: assert property (p_pump) else $error("pump code moved unwritten");
   property p_bleed; $changed(bleed_value) |-> age_q <= 8'd40; endproperty
   a_bleed: assert property (p_bleed) else $error("bleed moved unwritten");
endmodule : pscr_config_regs_asserts
bind pscr_config_regs pscr_config_regs_asserts i_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
   .load_strobe(load_strobe), .var_modulus(var_modulus), .int_value(int_value),
   .modulator_dither_en(modulator_dither_en), .coarse_numerator(coarse_numerator),
   .fine_numerator(fine_numerator), .fine_denominator(fine_denominator),
   .phase_adjust_en(phase_adjust_en), .phase_step(phase_step),
   .charge_pump_code(charge_pump_code), .bleed_value(bleed_value));
`default_nettype wire

// [dv/pscr_host_model.sv]
// host model driving the three-wire serial write link
`timescale 1ns/100ps
`default_nettype none
module pscr_host_model
(
   input  wire logic sys_clk,
   output logic      ser_clk,
   output logic      ser_data,
   output logic      load_strobe
);
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b1;
      load_strobe = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : hold
   // clock idles low between frames; data line shows no stale bit
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         ser_data <= w[i];
         hold(4);
         ser_clk <= 1'b1;
         hold(4);
         ser_clk <= 1'b0;
      end
      hold(4);
      load_strobe <= 1'b1;
      ser_data <= ~w[0];
      hold(4);
      load_strobe <= 1'b0;
      hold(4);
   endtask : send
endmodule : pscr_host_model
`default_nettype wire

// [dv/pscr_config_regs_tb.sv]
// self-checking bench for the synthesizer config bank
`timescale 1ns/100ps
`default_nettype none
`include "pscr_cfg.svh"
module pscr_config_regs_tb;
   logic        sys_clk, rst_n, ref_in, ref_present, lock_raw, strobe_align_en;
   logic        ser_clk, ser_data, load_strobe, phase_step, phase_adjust_en;
   logic        var_modulus, modulator_dither_en, extra_modulus_bit_off, prescaler_sel;
   logic        ref_half_divider_en, ref_doubler_en, bleed_negative, bleed_en;
   logic        sigma_delta_modulator_en, antibacklash_width, charge_pump_tristate;
   logic        power_down, counters_reset, lock_detect_out, lock_detect_oe;
   logic [15:0] int_value;
   logic [24:0] coarse_numerator;
   logic [23:0] fine_numerator, fine_denominator;
   logic [11:0] phase_value, resync_divider_one;
   logic [3:0]  charge_pump_code;
   logic [4:0]  ref_count;
   logic [7:0]  bleed_value;
   logic [1:0]  lock_window_precision;
   int          fail_count, checks, step_cnt, zero_cnt, sd_watch;
   logic [31:0] r6_tab [3] = '{32'h5AD9_0336, 32'h0001_0046, 32'h0000_0006};
   int          ld_tab [4] = '{0, 2, 3, 1};

   pscr_host_model i_host (.sys_clk, .ser_clk, .ser_data, .load_strobe);
   pscr_config_regs i_dut (.sys_clk, .rst_n, .ser_clk, .ser_data, .load_strobe, .ref_in,
      .ref_present, .lock_raw, .strobe_align_en, .var_modulus, .int_value,
      .modulator_dither_en, .coarse_numerator, .fine_numerator, .fine_denominator,
      .phase_adjust_en, .phase_value, .phase_step, .charge_pump_code, .extra_modulus_bit_off,
      .prescaler_sel, .ref_half_divider_en, .ref_doubler_en, .ref_count, .resync_divider_one,
      .bleed_value, .bleed_negative, .bleed_en, .sigma_delta_modulator_en,
      .antibacklash_width, .lock_window_precision, .charge_pump_tristate, .power_down,
      .counters_reset, .lock_detect_out, .lock_detect_oe);

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (phase_step === 1'b1) step_cnt++;
      if (sd_watch != 0 && coarse_numerator === 25'h0) zero_cnt++;
   end

   task automatic final_report;
      if (fail_count == 0 && checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // fixed wait covers sync plus receive latency
   task automatic wr(input logic [31:0] w);
      i_host.send(w);
      repeat (8) @(posedge sys_clk);
   endtask : wr
   task automatic chk_r6(input logic [31:0] w);
      chk(32'({bleed_value, bleed_negative, bleed_en}), 32'(w[31:22]));
      chk(32'({sigma_delta_modulator_en, antibacklash_width}), 32'({~w[20], w[19]}));
      chk(32'({lock_window_precision, charge_pump_tristate, power_down, counters_reset}),
          32'({w[9:8], w[16] | w[5], w[6], w[4]}));
   endtask : chk_r6

   initial
   begin
      rst_n = 1'b0;
      ref_in = 1'b1;
      ref_present = 1'b1;
      lock_raw = 1'b1;
      strobe_align_en = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(32'({sigma_delta_modulator_en, lock_detect_oe, int_value}), 32'h0002_0000);
      // ----------------------------------------
      // buffered frequency words, commit on zero
      // ----------------------------------------
      wr({1'b1, 2'h0, 25'h1234567, 4'h1});
      wr({1'b1, 15'h0, 12'h200, 4'h2});
      wr({4'h0, 24'hABCDEF, 4'h3});
      wr({4'h0, 24'h123456, 4'h4});
      wr(32'h0002_0006);
      chk(32'({modulator_dither_en, phase_adjust_en, coarse_numerator}), 32'h0);
      wr({3'h0, 1'b1, 8'h0, 16'd121, 4'h0});
      chk(32'({var_modulus, modulator_dither_en, phase_adjust_en, int_value}), 32'h7_0079);
      chk(32'(coarse_numerator), 32'h0123_4567);
      chk(32'(fine_numerator), 32'h00AB_CDEF);
      chk(32'(fine_denominator), 32'h0012_3456);
      chk(32'({phase_value, 4'(step_cnt)}), 32'h2001);
      wr({12'h0, 16'd200, 4'h0});
      chk(32'({fine_numerator, var_modulus}), 32'h0);
      chk(32'({fine_denominator, 4'(step_cnt)}), 32'h2);
      // ----------------------------------------
      // modulator reset window on commit
      // ----------------------------------------
      for (int s = 0; s < 2; s++)
      begin
         wr({14'h0, s[0], 13'h0, 4'h6});
         zero_cnt = 0;
         sd_watch = 1;
         wr({12'h0, 16'd200, 4'h0});
         repeat (8) @(posedge sys_clk);
         sd_watch = 0;
         chk(32'(zero_cnt >= 1 && zero_cnt <= `PSCR_SD_RST_CYC + 1), 32'(s == 0));
      end
      // ----------------------------------------
      // immediate config words and lock output
      // ----------------------------------------
      foreach (r6_tab[i])
      begin
         wr(r6_tab[i]);
         chk_r6(r6_tab[i]);
      end
      wr({2'b01, 1'b0, 4'hA, 4'hB, 5'h15, 12'hABC, 4'h5});
      chk(32'({charge_pump_code, extra_modulus_bit_off, prescaler_sel}), 32'h2A);
      chk(32'({ref_half_divider_en, ref_doubler_en, ref_count, resync_divider_one}),
          32'h7_5ABC);
      foreach (ld_tab[i])
      begin
         wr({ld_tab[i][1:0], 26'h0, 4'h5});
         chk(32'({lock_detect_oe, lock_detect_out}),
             32'({ld_tab[i] != 0, ld_tab[i] == 1 || ld_tab[i] == 2}));
      end
      wr(32'h0004_0006);
      ref_present <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk(32'(lock_detect_out), 32'h0);
      ref_present <= 1'b1;
      wr(32'h0000_0046);
      chk(32'({lock_detect_out, int_value}), 32'(16'd200));
      wr({28'hFFFF_FFF, 4'h7});
      wr({28'hFFFF_FFF, 4'hD});
      chk_r6(32'h0000_0046);
      chk(32'(int_value), 32'(16'd200));
      wr(32'h0000_0006);
      // ----------------------------------------
      // strobe held for reference falling edge
      // ----------------------------------------
      strobe_align_en <= 1'b1;
      wr(32'h0000_0016);
      chk(32'(counters_reset), 32'h0);
      ref_in <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk(32'(counters_reset), 32'h1);
      ref_in <= 1'b1;
      strobe_align_en <= 1'b0;
      rst_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(32'({counters_reset, int_value}), 32'h0);
      final_report();
   end
   initial
   begin
      fail_count = 0;
      checks = 0;
      step_cnt = 0;
      zero_cnt = 0;
      sd_watch = 0;
      repeat (40000) @(posedge sys_clk);
      fail_count++;
      final_report();
   end
endmodule : pscr_config_regs_tb
`default_nettype wire
